// >>> common/eft_pkg.sv
// shared constants and types for the eight-bit fine timer
`default_nettype none
package eft_pkg;
   // register word addresses (16-bit registers, one per aligned word)
   localparam logic [15:0] ADDR_CLKSEL = 16'h4200;
   localparam logic [15:0] ADDR_RELOAD = 16'h4202;
   localparam logic [15:0] ADDR_COUNT = 16'h4204;
   localparam logic [15:0] ADDR_CTRL = 16'h4206;
   localparam logic [15:0] ADDR_PSC = 16'h4020;
   // byte address is four times the printed offset
   localparam int ADDR_SHIFT = 2;
   // control register fields
   localparam int CTL_RUN = 0;
   localparam int CTL_RST = 1;
   localparam int CTL_ONESHOT = 4;
   localparam int CTL_FINE_LO = 8;
   localparam int CTL_FINE_HI = 11;
   localparam int PSC_RUN = 0;
   // reset values
   localparam logic [3:0] RST_DIVSEL = 4'h0;
   localparam logic [7:0] RST_RELOAD = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'hff;
   localparam logic [3:0] RST_FINE = 4'h0;
   localparam logic [3:0] DIV_RESERVED = 4'hf;
   localparam int PSC_WIDTH = 14;
   localparam logic [3:0] PERIOD_LAST = 4'hf;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_ACK = 3'b010,
      BUS_GAP = 3'b100
   } eft_bus_state_t;

   typedef struct packed {
      logic [3:0] dividerSelect;
      logic [7:0] reloadValue;
      logic [7:0] countValue;
      logic [3:0] fineDelayCount;
      logic oneShotSelect;
      logic runControl;
   } eft_regs_t;
endpackage
`default_nettype wire

// >>> src/eft_prescaler.sv
// prescaler, counting only while pscRun is set, giving one-cycle tap pulses per divide ratio
`default_nettype none
module eft_prescaler #(
   parameter int WIDTH = eft_pkg::PSC_WIDTH
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // control
   input wire logic pscRun,
   input wire logic [3:0] divSel,
   // tick out
   output logic tick
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic tick;
   } eft_psc_state_t;

   eft_psc_state_t stateFf;
   eft_psc_state_t nxtState;
   logic [WIDTH:0] tapPulse;

   // tap k pulses once every 2**k cycles: low k bits all ones
   assign tapPulse[0] = 1'b1;
   genvar gi;
   generate
      for (gi = 1; gi <= WIDTH; gi++) begin : gTap
         assign tapPulse[gi] = &stateFf.cnt[gi-1:0];
      end
   endgenerate

   always_comb begin
      nxtState = stateFf;
      nxtState.tick = 1'b0;
      if (pscRun) begin
         nxtState.cnt = stateFf.cnt + 1'b1;
         if (divSel != eft_pkg::DIV_RESERVED) begin
            nxtState.tick = tapPulse[divSel];
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         stateFf <= '0;
      end else begin
         stateFf <= nxtState;
      end
   end

   assign tick = stateFf.tick;
endmodule
`default_nettype wire

// >>> src/eft_timer.sv
// eight-bit down-counting reload timer with fine mode, Wishbone slave
`default_nettype none
module eft_timer (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // wishbone slave
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [17:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck,
   // events
   output logic underflow,
   output logic running
);
   typedef struct packed {
      eft_pkg::eft_regs_t regs;
      logic pscRun;
      logic [3:0] uflowCnt;
      logic delayPending;
      logic underflow;
      logic running;
      logic [31:0] rdata;
      logic ack;
      eft_pkg::eft_bus_state_t bus;
   } eft_state_t;

   eft_state_t stateFf;
   eft_state_t nxtState;
   logic tick;
   logic req;
   logic [15:0] wordAdr;
   logic [15:0] wdata;
   logic [15:0] rd;
   logic wrEn;
   logic delayHere;
   logic [4:0] slot;
   logic [8:0] scaled;
   logic [8:0] prevScaled;

   eft_prescaler #(
      .WIDTH(eft_pkg::PSC_WIDTH)
   ) uPsc (
      .mclk(mclk),
      .arst_n(arst_n),
      .pscRun(stateFf.pscRun),
      .divSel(stateFf.regs.dividerSelect),
      .tick(tick)
   );

   assign req = wbCyc && wbStb;
   assign wordAdr = wbAdr[17:eft_pkg::ADDR_SHIFT];
   assign wdata = wbDatW[15:0];

   // spread n delays evenly across the sixteen underflow slots
   assign slot = {1'b0, stateFf.uflowCnt} + 5'h01;
   // operands widened first: a five-bit product would wrap above 31
   assign scaled = {4'h0, slot} * {5'h00, stateFf.regs.fineDelayCount};
   assign prevScaled = {5'h00, stateFf.uflowCnt} *
      {5'h00, stateFf.regs.fineDelayCount};
   assign delayHere = (scaled[8:4] != prevScaled[8:4]);

   always_comb begin
      rd = 16'h0000;
      case (wordAdr)
         eft_pkg::ADDR_CLKSEL:
            rd = {12'h000, stateFf.regs.dividerSelect};
         eft_pkg::ADDR_RELOAD: rd = {8'h00, stateFf.regs.reloadValue};
         eft_pkg::ADDR_COUNT: rd = {8'h00, stateFf.regs.countValue};
         eft_pkg::ADDR_CTRL: begin
            rd[eft_pkg::CTL_FINE_HI:eft_pkg::CTL_FINE_LO] =
               stateFf.regs.fineDelayCount;
            rd[eft_pkg::CTL_ONESHOT] = stateFf.regs.oneShotSelect;
            rd[eft_pkg::CTL_RUN] = stateFf.regs.runControl;
         end
         eft_pkg::ADDR_PSC: rd[eft_pkg::PSC_RUN] = stateFf.pscRun;
         default: rd = 16'h0000;
      endcase
   end

   always_comb begin
      nxtState = stateFf;
      nxtState.underflow = 1'b0;
      wrEn = 1'b0;
      case (stateFf.bus)
         eft_pkg::BUS_IDLE: begin
            if (req) begin
               nxtState.ack = 1'b1;
               nxtState.rdata = {16'h0000, rd};
               nxtState.bus = eft_pkg::BUS_ACK;
               wrEn = wbWe;
            end
         end
         eft_pkg::BUS_ACK: begin
            nxtState.ack = 1'b0;
            nxtState.bus = eft_pkg::BUS_GAP;
         end
         eft_pkg::BUS_GAP: nxtState.bus = eft_pkg::BUS_IDLE;
         default: begin
            nxtState.ack = 1'b0;
            nxtState.bus = eft_pkg::BUS_IDLE;
         end
      endcase

      // count on tick, reload at underflow
      if (stateFf.regs.runControl && tick) begin
         if (stateFf.delayPending) begin
            nxtState.delayPending = 1'b0;
         end else if (stateFf.regs.countValue == 8'h00) begin
            nxtState.regs.countValue = stateFf.regs.reloadValue;
            nxtState.underflow = 1'b1;
            nxtState.uflowCnt = stateFf.uflowCnt + 4'h1;
            nxtState.delayPending = delayHere;
            if (stateFf.regs.oneShotSelect) begin
               nxtState.regs.runControl = 1'b0;
            end
         end else begin
            nxtState.regs.countValue = stateFf.regs.countValue - 8'h01;
         end
      end

      // software writes win over the counter in the same cycle
      if (wrEn) begin
         case (wordAdr)
            eft_pkg::ADDR_CLKSEL: if (wbSel[0]) begin
               nxtState.regs.dividerSelect = wdata[3:0];
            end
            eft_pkg::ADDR_RELOAD: if (wbSel[0]) begin
               nxtState.regs.reloadValue = wdata[7:0];
            end
            eft_pkg::ADDR_CTRL: begin
               if (wbSel[1]) begin
                  nxtState.regs.fineDelayCount =
                     wdata[eft_pkg::CTL_FINE_HI:eft_pkg::CTL_FINE_LO];
               end
               if (wbSel[0]) begin
                  nxtState.regs.oneShotSelect = wdata[eft_pkg::CTL_ONESHOT];
                  nxtState.regs.runControl = wdata[eft_pkg::CTL_RUN];
                  if (wdata[eft_pkg::CTL_RST]) begin
                     nxtState.regs.countValue = stateFf.regs.reloadValue;
                     nxtState.uflowCnt = 4'h0;
                     nxtState.delayPending = 1'b0;
                  end
               end
            end
            eft_pkg::ADDR_PSC: if (wbSel[0]) begin
               nxtState.pscRun = wdata[eft_pkg::PSC_RUN];
            end
            default: nxtState.pscRun = stateFf.pscRun;
         endcase
      end
      nxtState.running = nxtState.regs.runControl;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         stateFf.regs.dividerSelect <= eft_pkg::RST_DIVSEL;
         stateFf.regs.reloadValue <= eft_pkg::RST_RELOAD;
         stateFf.regs.countValue <= eft_pkg::RST_COUNT;
         stateFf.regs.fineDelayCount <= eft_pkg::RST_FINE;
         stateFf.regs.oneShotSelect <= 1'b0;
         stateFf.regs.runControl <= 1'b0;
         stateFf.pscRun <= 1'b0;
         stateFf.uflowCnt <= 4'h0;
         stateFf.delayPending <= 1'b0;
         stateFf.underflow <= 1'b0;
         stateFf.running <= 1'b0;
         stateFf.rdata <= 32'h0000_0000;
         stateFf.ack <= 1'b0;
         stateFf.bus <= eft_pkg::BUS_IDLE;
      end else begin
         stateFf <= nxtState;
      end
   end

   assign wbDatR = stateFf.rdata;
   assign wbAck = stateFf.ack;
   assign underflow = stateFf.underflow;
   assign running = stateFf.running;
endmodule
`default_nettype wire

// >>> verif/eft_checker.sv
// port assertions for the eight-bit fine timer
`default_nettype none
module eft_checker (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // bus
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic [31:0] wbDatR,
   input wire logic wbAck,
   // events
   input wire logic underflow,
   input wire logic running
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   ack_gap_a: assert property (wbAck |=> !wbAck [*2])
      else $error("ack without gap");
   ack_cause_a: assert property (wbAck |-> $past(wbCyc) && $past(wbStb))
      else $error("ack without request");
   ack_reply_a: assert property ($rose(wbStb) && wbCyc |=> wbAck)
      else $error("request not answered");
   read_upper_a: assert property (wbAck |-> wbDatR[31:16] == 16'h0)
      else $error("upper read bits set");
   run_rise_a: assert property ($rose(running) |-> wbAck || $past(wbAck))
      else $error("run began without write");
   run_fall_a: assert property ($fell(running) |->
      wbAck || $past(wbAck) || underflow || $past(underflow))
      else $error("run ended without cause");
   uflow_run_a: assert property (underflow |->
      $past(running) || $past(running, 2))
      else $error("underflow while stopped");
   stop_quiet_a: assert property (!running [*3] |=> !underflow)
      else $error("stopped timer underflowed");
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the eight-bit fine timer
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 0, arst_n = 0, wbCyc = 0, wbStb = 0, wbWe = 0;
   logic [3:0] wbSel = 4'h3;
   logic [17:0] wbAdr = '0;
   logic [31:0] wbDatW = '0, wbDatR, rd;
   logic wbAck, underflow, running;
   int n_errors = 0, samples_checked = 0, cyc = 0, n;
   eft_timer i_dut (.mclk(mclk), .arst_n(arst_n), .wbCyc(wbCyc),
      .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
      .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
      .underflow(underflow), .running(running));
   always #12.5 mclk = ~mclk;
   task automatic finish_test;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 6000) begin
         n_errors++;
         finish_test;
      end
   end
   task automatic chk(input logic [31:0] seen, exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   // classic cycle, held until ack is sampled
   task automatic bus(input logic we, input logic [15:0] a, d);
      @(posedge mclk);
      wbCyc <= 1;
      wbStb <= 1;
      wbWe <= we;
      wbAdr <= {a, 2'b00};
      wbDatW <= {16'h0, d};
      do @(posedge mclk); while (wbAck !== 1'b1);
      rd = wbDatR;
      wbCyc <= 0;
      wbStb <= 0;
   endtask
   task automatic t_regs;
      bus(0, eft_pkg::ADDR_CLKSEL, 0); chk(rd, 0, "clksel");
      bus(0, eft_pkg::ADDR_COUNT, 0); chk(rd, 32'hff, "count");
      bus(0, eft_pkg::ADDR_CTRL, 0); chk(rd, 0, "ctrl");
      bus(1, eft_pkg::ADDR_RELOAD, 16'ha5);
      bus(0, eft_pkg::ADDR_RELOAD, 0); chk(rd, 32'ha5, "reload");
      bus(1, eft_pkg::ADDR_COUNT, 16'h12);
      bus(0, eft_pkg::ADDR_COUNT, 0); chk(rd, 32'hff, "count ro");
      bus(1, eft_pkg::ADDR_CTRL, 16'h0f12);
      bus(0, eft_pkg::ADDR_CTRL, 0); chk(rd, 32'h0f10, "ctrl");
      bus(0, eft_pkg::ADDR_COUNT, 0); chk(rd, 32'ha5, "loaded");
      bus(1, eft_pkg::ADDR_RELOAD, 16'h33);
      bus(1, eft_pkg::ADDR_CTRL, 16'h0);
      bus(0, eft_pkg::ADDR_COUNT, 0); chk(rd, 32'ha5, "no load");
      bus(0, 16'h4208, 0); chk(rd, 0, "unmapped");
   endtask
   // prescaler left stopped: count must hold
   task automatic t_stop;
      bus(1, eft_pkg::ADDR_CTRL, 16'h0003);
      repeat (40) @(posedge mclk);
      chk(running, 1, "running");
      bus(0, eft_pkg::ADDR_COUNT, 0); chk(rd, 32'h33, "held");
      bus(1, eft_pkg::ADDR_CTRL, 16'h0);
   endtask
   // one-shot from reload 3 takes four ticks of 2^d cycles
   task automatic t_div(input int d);
      bus(1, eft_pkg::ADDR_RELOAD, 16'h3);
      bus(1, eft_pkg::ADDR_CLKSEL, 16'(d));
      bus(1, eft_pkg::ADDR_CTRL, 16'h0013);
      n = 0;
      while (underflow !== 1'b1 && n < 300) begin
         @(posedge mclk);
         n++;
      end
      chk(n >= (3 << d) && n <= (4 << d) + 3, 1, "ticks");
      repeat (3) @(posedge mclk);
      chk(running, 0, "one-shot");
      bus(0, eft_pkg::ADDR_COUNT, 0); chk(rd, 32'h3, "reload");
   endtask
   // reload 0: one underflow per tick, fine mode swallows ticks
   task automatic t_fine(input logic [3:0] f, input int lo, hi);
      bus(1, eft_pkg::ADDR_RELOAD, 16'h0);
      bus(1, eft_pkg::ADDR_CLKSEL, 16'h0);
      bus(1, eft_pkg::ADDR_CTRL, {4'h0, f, 8'h03});
      n = 0;
      repeat (64) begin
         @(posedge mclk);
         if (underflow === 1'b1)
            n++;
      end
      chk(n >= lo && n <= hi, 1, "fine rate");
      chk(running, 1, "repeat");
      bus(1, eft_pkg::ADDR_CTRL, 16'h0);
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      arst_n <= 1;
      t_regs;
      t_stop;
      bus(1, eft_pkg::ADDR_PSC, 16'h1);
      for (int d = 0; d < 3; d++)
         t_div(d);
      t_fine(4'h0, 62, 64);
      t_fine(4'hf, 30, 36);
      finish_test;
   end
endmodule
bind eft_timer eft_checker i_chk (.mclk(mclk), .arst_n(arst_n),
   .wbCyc(wbCyc), .wbStb(wbStb), .wbDatR(wbDatR), .wbAck(wbAck),
   .underflow(underflow), .running(running));
`default_nettype wire
